// ---- design/cori_regs.sv ----
// charger option, event flag and minimum system voltage register bank
//
// Contract
// - writing forced cut bit cuts the battery after the selected delay
// - with unplug cut set, cut battery on adapter removal until replug
// - fault block bit stops fault-class flags raising the interrupt
// - status block bit stops status-class flags raising the interrupt
// - option bits 6:4 read back the current charger phase code
// - delay select 00/01/10/11 gives 0/512/1024/2048 ms, default 10
// - bit 9 enables spread spectrum, default off
// - bit 10 enables CP exit, default off
// - termination current is 128 mA times code plus one, default 001
// - bit 14 selects linear regulator mode, resets to zero
// - bit 15 selects economy mode, default one
// - flag 0 set on end-of-charge, cleared by read, reset or off
// - flag 1 set on precharge entry, cleared by read, reset or off
// - flag 2 set on learn mode change, cleared by read
// - flag 3 set on host timer expiry, cleared by read, reset or off
// - flags 4,5,6,11 read-clear; flag 7 input short not cleared by read
// - flag 8 set on hard reset entry with forced cut; not off-cleared
// - flag 9 set on hard reset entry with unplug cut; not off-cleared
// - floor register bit 0 enables dynamic precharge, default on
// - bit 1 picks input-good source: threshold select or voltage floor
// - voltage floor in 128 mV steps, clamped at both ends
// - bit 15 enables cell-count floor detection, default on
// - writing one to flag 10 clears it
// - reading the flag register clears its read-clear flags
// - config fields return to defaults on entry to off phase
// - off-reset flags held at zero while phase is off
`timescale 1ns/1ps
module cori_regs #(
    parameter int CUT_UNIT = cori_pkg::CUT_UNIT_CYC,
    parameter logic [7:0] FLOOR_DEFAULT = cori_pkg::FLOOR_LOW_CLAMP
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // register port from the serial protocol engine
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // charger state and events, same clock
    input wire cori_pkg::cori_phase_t phase_i,
    input wire cori_pkg::cori_events_t events_i,
    // adapter presence pin
    input wire logic adapter_present_i,
    // controls to the power stage
    output logic battery_cut_o,
    output cori_pkg::cori_cfg_t cfg_o,
    output logic irq_o
);
    localparam logic [15:0] VMIN_DEFAULT = cori_pkg::VMIN_FIXED_DEFAULT
        | {1'b0, FLOOR_DEFAULT, 7'h00};

    logic [15:0] opt_reg;
    logic [15:0] vmin_reg;
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] flag_set;
    logic [2:0] phase_prev_reg;
    logic off_entry;
    logic in_off;
    logic [2:0] sync_reg;
    logic adapter_reg;
    logic unplug_cut_reg;
    logic [31:0] cut_cnt_reg;
    logic forced_done_reg;
    logic rd_flags;

    // ======================================================
    // helpers
    function automatic logic [31:0] cut_cycles(input logic [1:0] sel);
        logic [31:0] unit;
        unit = 32'(CUT_UNIT);
        unique case (sel)
            2'b00: cut_cycles = 32'h0;
            2'b01: cut_cycles = unit;
            2'b10: cut_cycles = unit << 1;
            2'b11: cut_cycles = unit << 2;
        endcase
    endfunction : cut_cycles

    function automatic logic [7:0] floor_clamp(input logic [7:0] code);
        if (code < cori_pkg::FLOOR_LOW_CLAMP) begin
            floor_clamp = cori_pkg::FLOOR_LOW_CLAMP;
        end else if (code > cori_pkg::FLOOR_HIGH_CLAMP) begin
            floor_clamp = cori_pkg::FLOOR_HIGH_CLAMP;
        end else begin
            floor_clamp = code;
        end
    endfunction : floor_clamp

    assign in_off = (phase_i == cori_pkg::PH_OFF);
    assign off_entry = in_off && (phase_prev_reg != 3'(cori_pkg::PH_OFF));
    assign rd_flags = reg_rd_i && (reg_addr_i == cori_pkg::FLAGS_ADDR);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase_prev_reg <= 3'(cori_pkg::PH_OFF);
        end else begin
            phase_prev_reg <= phase_i;
        end
    end

    // ======================================================
    // configuration registers
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || off_entry) begin
            opt_reg <= cori_pkg::OPT_DEFAULT;
            vmin_reg <= VMIN_DEFAULT;
        end else if (reg_wr_i) begin
            if (reg_addr_i == cori_pkg::OPT_ADDR) begin
                opt_reg <= reg_wdata_i & cori_pkg::OPT_RW_MASK;
            end
            if (reg_addr_i == cori_pkg::VMIN_ADDR) begin
                vmin_reg <= reg_wdata_i & cori_pkg::VMIN_RW_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_o <= '0;
        end else begin
            cfg_o.spread_spectrum_on <= opt_reg[cori_pkg::OPT_SPREAD];
            cfg_o.cp_leave_enable <= opt_reg[cori_pkg::OPT_CP_LEAVE];
            cfg_o.termination_current <= opt_reg[cori_pkg::OPT_TERM_LO +: 3];
            cfg_o.linear_regulation_select <= opt_reg[cori_pkg::OPT_LINEAR];
            cfg_o.eco_mode <= opt_reg[cori_pkg::OPT_ECO];
            cfg_o.dynamic_precharge_on <= vmin_reg[cori_pkg::VMIN_DYN_PRE];
            cfg_o.input_good_source <= vmin_reg[cori_pkg::VMIN_GOOD_SRC];
            cfg_o.system_voltage_floor <= floor_clamp(vmin_reg[cori_pkg::VMIN_FLOOR_LO +: 8]);
            cfg_o.cell_detect_on <= vmin_reg[cori_pkg::VMIN_CELL_DET];
        end
    end

    // ======================================================
    // adapter pin sync: change taken once stages two and three agree
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            // start at the idle level, present, so release gives no false unplug
            sync_reg <= 3'h7;
            adapter_reg <= 1'b1;
        end else begin
            sync_reg <= {sync_reg[1:0], adapter_present_i};
            if (sync_reg[1] == sync_reg[2]) begin
                adapter_reg <= sync_reg[2];
            end
        end
    end

    // ======================================================
    // battery cut
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            unplug_cut_reg <= 1'b0;
        end else if (adapter_reg) begin
            unplug_cut_reg <= 1'b0;
        end else if (opt_reg[cori_pkg::OPT_CUT_UNPLUG] && sync_reg[2] == sync_reg[1] && !sync_reg[2]) begin
            unplug_cut_reg <= 1'b1;
        end
    end

    // delay restarts whenever the forced cut bit is cleared
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !opt_reg[cori_pkg::OPT_FORCED_CUT]) begin
            cut_cnt_reg <= 32'h0;
            forced_done_reg <= 1'b0;
        end else if (cut_cnt_reg >= cut_cycles(opt_reg[cori_pkg::OPT_DELAY_LO +: 2])) begin
            forced_done_reg <= 1'b1;
        end else begin
            cut_cnt_reg <= cut_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            battery_cut_o <= 1'b0;
        end else begin
            battery_cut_o <= forced_done_reg || unplug_cut_reg;
        end
    end

    // ======================================================
    // event flags: set wins over read and write-one clears in the same cycle; the off-phase clear wins over set
    always_comb begin
        flag_set = '0;
        flag_set[cori_pkg::FLG_EOC] = (phase_i == cori_pkg::PH_END)
            && (phase_prev_reg != 3'(cori_pkg::PH_END));
        flag_set[cori_pkg::FLG_PRE] = (phase_i == cori_pkg::PH_PRECHARGE)
            && (phase_prev_reg != 3'(cori_pkg::PH_PRECHARGE));
        flag_set[cori_pkg::FLG_LEARN] = events_i.learn_change;
        flag_set[cori_pkg::FLG_HOST_TMR] = events_i.host_timer_expiry;
        flag_set[cori_pkg::FLG_PEAK] = events_i.peak_current;
        flag_set[cori_pkg::FLG_IN_OV] = events_i.input_overvoltage;
        flag_set[cori_pkg::FLG_CONV_OV] = events_i.converter_overvoltage;
        flag_set[cori_pkg::FLG_IN_SHORT] = events_i.input_short;
        flag_set[cori_pkg::FLG_SYS_OV] = events_i.system_overvoltage;
        flag_set[cori_pkg::FLG_BAT_GONE] = events_i.battery_gone;
        flag_set[cori_pkg::FLG_FORCED_CUT] = (phase_i == cori_pkg::PH_HARD_RESET)
            && (phase_prev_reg != 3'(cori_pkg::PH_HARD_RESET))
            && opt_reg[cori_pkg::OPT_FORCED_CUT];
        flag_set[cori_pkg::FLG_UNPLUG_CUT] = (phase_i == cori_pkg::PH_HARD_RESET)
            && (phase_prev_reg != 3'(cori_pkg::PH_HARD_RESET))
            && opt_reg[cori_pkg::OPT_CUT_UNPLUG];
        flags_next = flags_reg;
        if (rd_flags) begin
            flags_next = flags_next & ~cori_pkg::FLG_RC_MASK;
        end
        if (reg_wr_i && reg_addr_i == cori_pkg::FLAGS_ADDR) begin
            flags_next = flags_next & ~(reg_wdata_i & cori_pkg::FLG_W1C_MASK);
        end
        flags_next = flags_next | flag_set;
        if (in_off) begin
            flags_next = flags_next & ~cori_pkg::FLG_OFF_MASK;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flags_reg <= 16'h0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags_reg & ~({16{opt_reg[cori_pkg::OPT_FAULT_BLK]}} & cori_pkg::FLG_FAULT_MASK)
                & ~({16{opt_reg[cori_pkg::OPT_STATUS_BLK]}} & cori_pkg::FLG_STATUS_MASK));
        end
    end

    // ======================================================
    // read path: data one cycle after the read strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                cori_pkg::OPT_ADDR: begin
                    reg_rdata_o <= opt_reg | (16'(phase_i) << cori_pkg::OPT_STATE_LO);
                end
                cori_pkg::FLAGS_ADDR: reg_rdata_o <= flags_reg;
                cori_pkg::VMIN_ADDR: reg_rdata_o <= vmin_reg;
                default: reg_rdata_o <= 16'h0;
            endcase
        end
    end

    // ======================================================
    // checks
    phase_readback_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_rd_i && reg_addr_i == cori_pkg::OPT_ADDR
        |=> reg_rdata_o[cori_pkg::OPT_STATE_LO +: 3] == $past(phase_i))
        else $error("phase readback wrong");
    off_entry_default_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        off_entry |=> opt_reg == cori_pkg::OPT_DEFAULT && vmin_reg == VMIN_DEFAULT)
        else $error("defaults not restored on off entry");
    off_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        in_off |=> (flags_reg & cori_pkg::FLG_OFF_MASK) == 16'h0)
        else $error("off flags not held");
    read_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_flags && flag_set == 16'h0 |=> (flags_reg & cori_pkg::FLG_RC_MASK) == 16'h0)
        else $error("read did not clear flags");
    short_kept_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_flags && !in_off && flags_reg[cori_pkg::FLG_IN_SHORT] |=> flags_reg[cori_pkg::FLG_IN_SHORT])
        else $error("input short cleared by read");
    sysov_w1c_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == cori_pkg::FLAGS_ADDR && reg_wdata_i[cori_pkg::FLG_SYS_OV]
        && !events_i.system_overvoltage |=> !flags_reg[cori_pkg::FLG_SYS_OV])
        else $error("system overvoltage not cleared");
    eoc_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        phase_i == cori_pkg::PH_END && $past(phase_i) != cori_pkg::PH_END
        |=> flags_reg[cori_pkg::FLG_EOC] ##1 irq_o || opt_reg[cori_pkg::OPT_STATUS_BLK])
        else $error("end of charge flag or interrupt missing");
    irq_blocked_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        opt_reg[cori_pkg::OPT_FAULT_BLK] && opt_reg[cori_pkg::OPT_STATUS_BLK] |=> !irq_o)
        else $error("interrupt raised while blocked");
    forced_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        opt_reg[cori_pkg::OPT_FORCED_CUT] && opt_reg[cori_pkg::OPT_DELAY_LO +: 2] == 2'b00
        [*3] |-> battery_cut_o)
        else $error("zero delay cut missing");
    unplug_cut_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(unplug_cut_reg) |=> battery_cut_o)
        else $error("unplug cut not driven");
    forced_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        phase_i == cori_pkg::PH_HARD_RESET && $past(phase_i) != cori_pkg::PH_HARD_RESET
        && opt_reg[cori_pkg::OPT_FORCED_CUT] |=> flags_reg[cori_pkg::FLG_FORCED_CUT])
        else $error("forced cut flag missing");
    unplug_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        phase_i == cori_pkg::PH_HARD_RESET && $past(phase_i) != cori_pkg::PH_HARD_RESET
        && opt_reg[cori_pkg::OPT_CUT_UNPLUG] |=> flags_reg[cori_pkg::FLG_UNPLUG_CUT])
        else $error("unplug cut flag missing");
    status_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        flags_reg[cori_pkg::FLG_EOC] && !opt_reg[cori_pkg::OPT_STATUS_BLK] |=> irq_o)
        else $error("status interrupt missing");
    fault_irq_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        flags_reg[cori_pkg::FLG_IN_SHORT] && !opt_reg[cori_pkg::OPT_FAULT_BLK] |=> irq_o)
        else $error("fault interrupt missing");
    floor_range_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !rst_i |=> cfg_o.system_voltage_floor >= cori_pkg::FLOOR_LOW_CLAMP
        && cfg_o.system_voltage_floor <= cori_pkg::FLOOR_HIGH_CLAMP)
        else $error("voltage floor outside clamps");
    cut_release_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !opt_reg[cori_pkg::OPT_FORCED_CUT] && !unplug_cut_reg [*3] |-> !battery_cut_o)
        else $error("battery cut held without cause");
endmodule : cori_regs

// ---- design/cori_pkg.sv ----
// constants and carrier types of the charger option and event register bank
package cori_pkg;
    // ======================================================
    // register offsets
    localparam logic [7:0] OPT_ADDR = 8'h3c;
    localparam logic [7:0] FLAGS_ADDR = 8'h3d;
    localparam logic [7:0] VMIN_ADDR = 8'h3e;

    // ======================================================
    // option register fields
    localparam int OPT_FORCED_CUT = 0;
    localparam int OPT_CUT_UNPLUG = 1;
    localparam int OPT_FAULT_BLK = 2;
    localparam int OPT_STATUS_BLK = 3;
    localparam int OPT_STATE_LO = 4;
    localparam int OPT_DELAY_LO = 7;
    localparam int OPT_SPREAD = 9;
    localparam int OPT_CP_LEAVE = 10;
    localparam int OPT_TERM_LO = 11;
    localparam int OPT_LINEAR = 14;
    localparam int OPT_ECO = 15;
    localparam logic [15:0] OPT_RW_MASK = 16'hff8f;
    localparam logic [15:0] OPT_DEFAULT = 16'h8900;

    // ======================================================
    // event flag positions and classes
    localparam int FLG_EOC = 0;
    localparam int FLG_PRE = 1;
    localparam int FLG_LEARN = 2;
    localparam int FLG_HOST_TMR = 3;
    localparam int FLG_PEAK = 4;
    localparam int FLG_IN_OV = 5;
    localparam int FLG_CONV_OV = 6;
    localparam int FLG_IN_SHORT = 7;
    localparam int FLG_FORCED_CUT = 8;
    localparam int FLG_UNPLUG_CUT = 9;
    localparam int FLG_SYS_OV = 10;
    localparam int FLG_BAT_GONE = 11;
    localparam logic [15:0] FLG_RC_MASK = 16'h0b7f;
    localparam logic [15:0] FLG_W1C_MASK = 16'h0400;
    localparam logic [15:0] FLG_OFF_MASK = 16'h0cff;
    localparam logic [15:0] FLG_FAULT_MASK = 16'h0cf8;
    localparam logic [15:0] FLG_STATUS_MASK = 16'h0307;

    // ======================================================
    // minimum system voltage register
    localparam int VMIN_DYN_PRE = 0;
    localparam int VMIN_GOOD_SRC = 1;
    localparam int VMIN_FLOOR_LO = 7;
    localparam int VMIN_CELL_DET = 15;
    localparam logic [15:0] VMIN_RW_MASK = 16'hff83;
    localparam logic [15:0] VMIN_FIXED_DEFAULT = 16'h8001;
    localparam logic [7:0] FLOOR_LOW_CLAMP = 8'h1a;
    localparam logic [7:0] FLOOR_HIGH_CLAMP = 8'h8b;

    // ======================================================
    // timing: base cut delay 512 ms at 250 MHz
    localparam int CUT_UNIT_MS = 512;
    localparam int CLK_MHZ = 250;
    localparam int CUT_UNIT_CYC = CUT_UNIT_MS * 1000 * CLK_MHZ;

    // ======================================================
    // charger phases and carriers
    typedef enum logic [2:0] {
        PH_OFF, PH_CONFIG, PH_HOLD, PH_PRECHARGE,
        PH_FULL, PH_SUPPLEMENT, PH_END, PH_HARD_RESET
    } cori_phase_t;

    typedef struct packed {
        logic learn_change;
        logic host_timer_expiry;
        logic peak_current;
        logic input_overvoltage;
        logic converter_overvoltage;
        logic input_short;
        logic system_overvoltage;
        logic battery_gone;
    } cori_events_t;

    typedef struct packed {
        logic spread_spectrum_on;
        logic cp_leave_enable;
        logic [2:0] termination_current;
        logic linear_regulation_select;
        logic eco_mode;
        logic dynamic_precharge_on;
        logic input_good_source;
        logic [7:0] system_voltage_floor;
        logic cell_detect_on;
    } cori_cfg_t;
endpackage : cori_pkg

// ---- tb/cori_host.sv ----
// host model that drives the register strobe port
`timescale 1ns/1ps
module cori_host (
    // clock
    input wire logic ref_clk_i,
    // read data from the bank
    input wire logic [15:0] reg_rdata_i,
    // strobe port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [15:0] reg_wdata_o
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end

    // ==========================================
    // bus cycles
    // idle address and data are inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        q = reg_rdata_i;
    endtask : rd
endmodule : cori_host

// ---- tb/tb_top.sv ----
// self-checking bench of the charger option and event register bank
`timescale 1ns/1ps
module tb_top;
    localparam int UNIT = 8;
    logic ref_clk_i;
    logic rst_i;
    logic [7:0] a;
    logic wr;
    logic rd;
    logic [15:0] wd;
    logic [15:0] rdata;
    cori_pkg::cori_phase_t ph;
    cori_pkg::cori_events_t ev;
    cori_pkg::cori_cfg_t cfg;
    logic adp;
    logic cut;
    logic irq;
    int errors;
    int comparisons;
    int n;
    logic [15:0] opt;
    logic [15:0] flg;
    logic [15:0] vmin;
    logic [15:0] q;

    cori_regs #(.CUT_UNIT(UNIT)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(a), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .phase_i(ph), .events_i(ev),
        .adapter_present_i(adp), .battery_cut_o(cut), .cfg_o(cfg), .irq_o(irq));
    cori_host host (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_addr_o(a), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_wdata_o(wd));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // ==========================================
    // reference model
    function automatic logic [15:0] model(input logic [7:0] x);
        if (x == cori_pkg::OPT_ADDR)
            return (opt & cori_pkg::OPT_RW_MASK) | {9'h0, ph, 4'h0};
        if (x == cori_pkg::FLAGS_ADDR)
            return flg;
        if (x == cori_pkg::VMIN_ADDR)
            return vmin;
        return 16'h0000;
    endfunction : model

    function automatic logic [17:0] cfg_exp();
        logic [7:0] f;
        f = vmin[14:7];
        if (f < cori_pkg::FLOOR_LOW_CLAMP)
            f = cori_pkg::FLOOR_LOW_CLAMP;
        if (f > cori_pkg::FLOOR_HIGH_CLAMP)
            f = cori_pkg::FLOOR_HIGH_CLAMP;
        return {opt[9], opt[10], opt[13:11], opt[14], opt[15], vmin[0], vmin[1], f, vmin[15]};
    endfunction : cfg_exp

    function automatic logic irq_exp();
        return ((flg & cori_pkg::FLG_FAULT_MASK) != 16'h0 && !opt[2]) ||
            ((flg & cori_pkg::FLG_STATUS_MASK) != 16'h0 && !opt[3]);
    endfunction : irq_exp

    // ==========================================
    // checks and stimulus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdx(input logic [7:0] x);
        logic [15:0] e;
        e = model(x);
        host.rd(x, q);
        chk(q, e);
        if (x == cori_pkg::FLAGS_ADDR)
            flg = flg & ~cori_pkg::FLG_RC_MASK;
    endtask : rdx

    task automatic wrx(input logic [7:0] x, input logic [15:0] d);
        host.wr(x, d);
        if (x == cori_pkg::OPT_ADDR)
            opt = d & cori_pkg::OPT_RW_MASK;
        if (x == cori_pkg::VMIN_ADDR)
            vmin = d & cori_pkg::VMIN_RW_MASK;
        if (x == cori_pkg::FLAGS_ADDR)
            flg = flg & ~(d & cori_pkg::FLG_W1C_MASK);
    endtask : wrx

    task automatic chk_irq();
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk(irq, irq_exp());
    endtask : chk_irq

    task automatic set_phase(input cori_pkg::cori_phase_t p);
        @(posedge ref_clk_i);
        if (p == cori_pkg::PH_OFF && ph != cori_pkg::PH_OFF) begin
            opt = cori_pkg::OPT_DEFAULT;
            vmin = cori_pkg::VMIN_FIXED_DEFAULT | {1'b0, cori_pkg::FLOOR_LOW_CLAMP, 7'h00};
            flg = flg & ~cori_pkg::FLG_OFF_MASK;
        end
        if (p != ph && p == cori_pkg::PH_PRECHARGE)
            flg = flg | 16'h0002;
        if (p != ph && p == cori_pkg::PH_END)
            flg = flg | 16'h0001;
        if (p != ph && p == cori_pkg::PH_HARD_RESET)
            flg = flg | {6'h00, opt[1:0], 8'h00};
        ph <= p;
        repeat (2) @(posedge ref_clk_i);
    endtask : set_phase

    task automatic evp(input logic [7:0] v);
        @(posedge ref_clk_i);
        ev <= v;
        @(posedge ref_clk_i);
        ev <= '0;
        if (ph != cori_pkg::PH_OFF)
            flg = flg | {4'h0, v[0], v[1], 2'b00, v[2], v[3], v[4], v[5], v[6], v[7], 2'b00};
    endtask : evp

    task automatic test_done();
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    initial begin
        #200000;
        errors++;
        test_done();
    end

    // ==========================================
    // scenarios
    initial begin
        errors = 0;
        comparisons = 0;
        rst_i = 1'b1;
        ph = cori_pkg::PH_CONFIG;
        ev = '0;
        adp = 1'b1;
        opt = cori_pkg::OPT_DEFAULT;
        flg = 16'h0000;
        vmin = cori_pkg::VMIN_FIXED_DEFAULT | {1'b0, cori_pkg::FLOOR_LOW_CLAMP, 7'h00};
        void'($urandom(84196));
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        for (int x = 8'h3c; x <= 8'h3f; x++)
            rdx(8'(x));
        chk(cfg, cfg_exp());
        for (int i = 0; i < 6; i++) begin
            wrx(cori_pkg::OPT_ADDR, 16'($urandom) & 16'hfffc);
            rdx(cori_pkg::OPT_ADDR);
            wrx(cori_pkg::VMIN_ADDR, i == 0 ? 16'h0000 : i == 1 ? 16'hffff : 16'($urandom));
            rdx(cori_pkg::VMIN_ADDR);
            chk(cfg, cfg_exp());
        end
        host.wr(8'h3f, 16'hffff);
        rdx(8'h3f);
        // phase codes, with entry flags for precharge and end of charge
        wrx(cori_pkg::OPT_ADDR, 16'h0000);
        for (int p = 1; p < 8; p++) begin
            set_phase(cori_pkg::cori_phase_t'(p));
            rdx(cori_pkg::OPT_ADDR);
        end
        chk_irq();
        wrx(cori_pkg::OPT_ADDR, 16'h0008);
        chk_irq();
        rdx(cori_pkg::FLAGS_ADDR);
        set_phase(cori_pkg::PH_CONFIG);
        for (int i = 0; i < 10; i++) begin
            wrx(cori_pkg::OPT_ADDR, {12'h000, 2'(i), 2'b00});
            evp(8'($urandom));
            chk_irq();
            if (i % 2 == 1)
                rdx(cori_pkg::FLAGS_ADDR);
        end
        wrx(cori_pkg::FLAGS_ADDR, 16'hffff);
        rdx(cori_pkg::FLAGS_ADDR);
        // hard reset entry with both cut controls, then off
        wrx(cori_pkg::OPT_ADDR, 16'hff8b);
        evp(8'hff);
        set_phase(cori_pkg::PH_HARD_RESET);
        set_phase(cori_pkg::PH_OFF);
        evp(8'hff);
        rdx(cori_pkg::OPT_ADDR);
        rdx(cori_pkg::VMIN_ADDR);
        chk(cfg, cfg_exp());
        rdx(cori_pkg::FLAGS_ADDR);
        rdx(cori_pkg::FLAGS_ADDR);
        set_phase(cori_pkg::PH_CONFIG);
        // forced cut delay for every delay code
        for (int d = 0; d < 4; d++) begin
            wrx(cori_pkg::OPT_ADDR, {7'h00, 2'(d), 7'h01});
            n = 0;
            do begin
                @(posedge ref_clk_i);
                #1;
                n++;
            end while (cut !== 1'b1 && n < 200);
            chk(n, d == 0 ? 2 : (UNIT << (d - 1)) + 2);
            wrx(cori_pkg::OPT_ADDR, 16'h0000);
            repeat (3) @(posedge ref_clk_i);
            #1;
            chk(cut, 1'b0);
        end
        // cut on adapter removal until it returns
        wrx(cori_pkg::OPT_ADDR, 16'h0002);
        @(posedge ref_clk_i);
        adp <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        chk(cut, 1'b1);
        @(posedge ref_clk_i);
        adp <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        chk(cut, 1'b0);
        test_done();
    end
endmodule : tb_top
